// ---- design/otpg_params.svh ----
// Register indices, field layout, reset values and pattern codes of the test pattern generator
`ifndef OTPG_PARAMS_SVH
`define OTPG_PARAMS_SVH
`define IDX_WORD_ONE_LO     6'h33
`define IDX_WORD_ONE_HI     6'h34
`define IDX_WORD_TWO_LO     6'h35
`define IDX_WORD_TWO_HI     6'h36
`define IDX_PATTERN_SELECT  6'h37
`define IDX_PATTERN_RESTART 6'h3A
`define IDX_PATTERN_STATUS  6'h3B
`define USER_BYTE_COUNT     4
`define ADDR_LSB            2
`define SEL_W               4
`define RESTART_EN_BIT      0
`define RESTART_PULSE_BIT   1
`define STATUS_PHASE_BIT    0
`define STATUS_FULL_BIT     1
`define STATUS_ARMED_BIT    2
`define RST_BYTE            8'h00
`define RST_SELECT          4'h0
`define RST_BIT             1'b0
`define CODE_NORMAL         4'h0
`define CODE_ZEROS          4'h1
`define CODE_ONES           4'h2
`define CODE_TOGGLE         4'h3
`define CODE_RAMP           4'h4
`define CODE_SINGLE         4'h6
`define CODE_DOUBLE         4'h7
`define CODE_DESKEW         4'h8
`define RAMP_TOP            16'h4000
`define DESKEW_WORD         16'h0FFF
`define SAMPLE_W            16
`define BUF_DEPTH           2
`endif

// ---- design/otpg_pkg.sv ----
// Types shared by the test pattern generator modules
package otpg_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [15:0] user_word_t;
    typedef logic [3:0]  pattern_code_t;
    typedef logic [5:0]  reg_index_t;
endpackage

// ---- design/sample_stream_if.sv ----
// Valid/ready sample stream between the generator and its output buffer
`timescale 1ns/1ns
interface sample_stream_if #(
    parameter int DATA_W = 16
);
    logic              valid;
    logic              ready;
    logic [DATA_W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// ---- design/pattern_sequencer.sv ----
// Sequence state of the running test pattern: word phase and ramp count
`timescale 1ns/1ns
`include "otpg_params.svh"
module pattern_sequencer #(
    parameter int DATA_W = `SAMPLE_W
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Control
    input  wire logic              advance,
    input  wire logic              restart,
    // Sequence state
    output logic                   phase,
    output logic [DATA_W-1:0]      ramp
);
    logic              phase_reg;
    logic              phase_next;
    logic [DATA_W-1:0] ramp_reg;
    logic [DATA_W-1:0] ramp_next;
    wire  logic        ramp_at_top;

    assign ramp_at_top = (ramp_reg == DATA_W'(`RAMP_TOP));
    // Restart wins over a word taken in the same cycle
    assign phase_next  = restart ? 1'b0 : (advance ? ~phase_reg : phase_reg);    // [R8] [R3] [R6]
    assign ramp_next   = restart ? '0 :
                         (advance ? (ramp_at_top ? '0 : ramp_reg + DATA_W'(1)) : ramp_reg);  // [R4] [R8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 1'b0;
            ramp_reg  <= '0;
        end else begin
            phase_reg <= phase_next;
            ramp_reg  <= ramp_next;
        end
    end

    assign phase = phase_reg;
    assign ramp  = ramp_reg;
endmodule

// ---- design/pattern_out_buffer.sv ----
// Small FIFO between the generator and the downstream output path
`timescale 1ns/1ns
`include "otpg_params.svh"
module pattern_out_buffer #(
    parameter int DATA_W = `SAMPLE_W,
    parameter int DEPTH  = `BUF_DEPTH
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Filling side
    sample_stream_if.sink          fill,
    // Draining side
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [DATA_W-1:0]      out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pattern_out_buffer: DEPTH must be a power of two, at least 2");
    end

    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic [PTR_W-1:0]  rd_ptr_reg;
    logic [PTR_W:0]    count_reg;
    wire  logic        push;
    wire  logic        pop;

    // Ready depends only on the fill level, so a stalled drain really fills the buffer
    assign fill.ready = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid  = (count_reg != '0);
    assign push       = fill.valid && fill.ready;
    assign pop        = out_valid && out_ready;
    assign out_data   = mem[rd_ptr_reg];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= fill.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= push ? wr_ptr_reg + PTR_W'(1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_ptr_reg + PTR_W'(1) : rd_ptr_reg;
            count_reg  <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

// ---- design/output_test_pattern_generator.sv ----
// Test pattern generator for one converter channel output, with APB configuration registers
//
// What this block does
// [R1] Normal code passes converter samples unchanged
// [R2] Zeros code drives all low, ones all high
// [R3] Toggle code alternates 1010 word and complement
// [R4] Ramp code counts up each word, wraps after top
// [R5] Single code outputs user word one always
// [R6] Double code alternates user words one and two
// [R7] Deskew code outputs fixed deskew word always
// [R8] Enabled restart pulse returns sequence to start
// [R9] Restart pulse ignored while restart enable clear
// [R10] Select, pulse and enable reset to zero
// [R11] Two 16-bit user words from byte registers
// [R12] Undefined codes behave like normal operation
// [R13] Code changes apply only at word boundaries
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "otpg_params.svh"
module output_test_pattern_generator #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = `SAMPLE_W,
    parameter int DEPTH  = `BUF_DEPTH
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Converter sample input
    input  wire logic              sample_valid,
    output logic                   sample_ready,
    input  wire logic [DATA_W-1:0] sample_data,
    // Patterned output towards the link transmitter path
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [DATA_W-1:0]      out_data
);
    // The byte-wide map needs index 0x3B times four, and an odd width breaks the toggle word
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("output_test_pattern_generator: ADDR_W must lie in 8..32");
    end
    if (DATA_W < 16 || (DATA_W % 2) != 0) begin : g_bad_data
        $error("output_test_pattern_generator: DATA_W must be even and at least 16");
    end

    localparam int WORD_BYTES = `USER_BYTE_COUNT;

    // APB decode
    wire  logic                  setup_phase;
    wire  logic                  access_phase;
    wire  otpg_pkg::reg_index_t  reg_index;
    wire  logic                  addr_upper_zero;
    wire  logic                  hit_select;
    wire  logic                  hit_restart;
    wire  logic                  hit_status;
    wire  logic                  hit_user;
    wire  logic                  hit_any;
    wire  logic                  write_strobe;
    wire  otpg_pkg::reg_byte_t   write_byte;

    // Configuration registers
    otpg_pkg::pattern_code_t     select_reg;
    otpg_pkg::pattern_code_t     select_next;
    logic                        restart_pulse_reg;
    logic                        restart_pulse_next;
    logic                        restart_enable_reg;
    logic                        restart_enable_next;
    logic                        pulse_prev_reg;
    otpg_pkg::reg_byte_t         user_byte_reg [WORD_BYTES];
    logic [WORD_BYTES-1:0]       user_hit;
    otpg_pkg::reg_byte_t         user_read [WORD_BYTES];

    // Read path
    logic [31:0]                 prdata_reg;
    logic [31:0]                 prdata_next;
    wire  otpg_pkg::reg_byte_t   select_read;
    wire  otpg_pkg::reg_byte_t   restart_read;
    wire  otpg_pkg::reg_byte_t   status_read;
    otpg_pkg::reg_byte_t         user_read_any;

    // Pattern path
    wire  otpg_pkg::user_word_t  user_word_one;
    wire  otpg_pkg::user_word_t  user_word_two;
    wire  logic                  restart_fire;
    wire  logic                  word_taken;
    wire  logic                  seq_phase;
    wire  logic [DATA_W-1:0]     seq_ramp;
    wire  logic [DATA_W-1:0]     toggle_word;
    wire  logic [DATA_W-1:0]     pattern_word;
    wire  logic                  code_is_pattern;

    sample_stream_if #(.DATA_W(DATA_W)) gen_stream ();

    // ------------------------------------------------------------------
    // APB slave: zero wait states, error on unmapped index
    // ------------------------------------------------------------------
    assign setup_phase     = psel && !penable;
    assign access_phase    = psel && penable;
    assign reg_index       = paddr[`ADDR_LSB +: 6];
    assign addr_upper_zero = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;

    assign hit_select  = addr_upper_zero && (reg_index == `IDX_PATTERN_SELECT);
    assign hit_restart = addr_upper_zero && (reg_index == `IDX_PATTERN_RESTART);
    assign hit_status  = addr_upper_zero && (reg_index == `IDX_PATTERN_STATUS);
    assign hit_user    = |user_hit;
    assign hit_any     = hit_select || hit_restart || hit_status || hit_user;

    // Only byte lane 0 carries register data; other lanes are ignored
    assign write_strobe = access_phase && pwrite && pstrb[0] && hit_any;
    assign write_byte   = pwdata[7:0];

    assign pready  = 1'b1;
    assign pslverr = access_phase && !hit_any;
    assign prdata  = prdata_reg;

    // ------------------------------------------------------------------
    // User pattern word bytes, one register per printed index
    // ------------------------------------------------------------------
    for (genvar i = 0; i < WORD_BYTES; i++) begin : g_user_byte
        assign user_hit[i]  = addr_upper_zero && (reg_index == `IDX_WORD_ONE_LO + 6'(i));
        assign user_read[i] = user_hit[i] ? user_byte_reg[i] : `RST_BYTE;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                user_byte_reg[i] <= `RST_BYTE;                                  // [R11]
            end else if (write_strobe && user_hit[i]) begin
                user_byte_reg[i] <= write_byte;                                 // [R11]
            end
        end
    end

    always_comb begin
        user_read_any = `RST_BYTE;
        for (int j = 0; j < WORD_BYTES; j++) begin
            user_read_any = user_read_any | user_read[j];
        end
    end

    // Low byte at the lower index, high byte at the next one
    assign user_word_one = {user_byte_reg[1], user_byte_reg[0]};                // [R11]
    assign user_word_two = {user_byte_reg[3], user_byte_reg[2]};                // [R11]

    // ------------------------------------------------------------------
    // Pattern select and restart control
    // ------------------------------------------------------------------
    assign select_next         = (write_strobe && hit_select) ? write_byte[`SEL_W-1:0] : select_reg;
    assign restart_pulse_next  = (write_strobe && hit_restart) ? write_byte[`RESTART_PULSE_BIT]
                                                               : restart_pulse_reg;
    assign restart_enable_next = (write_strobe && hit_restart) ? write_byte[`RESTART_EN_BIT]
                                                               : restart_enable_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg         <= `RST_SELECT;                                  // [R10]
            restart_pulse_reg  <= `RST_BIT;                                     // [R10]
            restart_enable_reg <= `RST_BIT;                                     // [R10]
            pulse_prev_reg     <= `RST_BIT;
        end else begin
            select_reg         <= select_next;
            restart_pulse_reg  <= restart_pulse_next;
            restart_enable_reg <= restart_enable_next;
            pulse_prev_reg     <= restart_pulse_reg;
        end
    end

    // A restart is the rising edge of the pulse bit, honoured only while enabled.
    // A pulse bit left high does not keep the pattern in restart.
    assign restart_fire = restart_pulse_reg && !pulse_prev_reg && restart_enable_reg;  // [R8] [R9]

    // ------------------------------------------------------------------
    // Read data, captured in the setup phase so it is stable in access
    // ------------------------------------------------------------------
    assign select_read  = {4'h0, select_reg};
    assign restart_read = {6'h00, restart_pulse_reg, restart_enable_reg};
    assign status_read  = {5'h00, restart_enable_reg, !gen_stream.ready, seq_phase};

    assign prdata_next = !(setup_phase && !pwrite) ? prdata_reg :
                         hit_select  ? {24'h000000, select_read}  :
                         hit_restart ? {24'h000000, restart_read} :
                         hit_status  ? {24'h000000, status_read}  :
                                       {24'h000000, user_read_any};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Pattern sequence state, stepped once per word taken
    // ------------------------------------------------------------------
    // Patterns are paced by the converter samples, so a test word replaces each sample one for one
    assign word_taken   = sample_valid && gen_stream.ready;
    assign sample_ready = gen_stream.ready;

    pattern_sequencer #(
        .DATA_W  (DATA_W)
    ) u_sequencer (
        .pclk    (pclk),
        .presetn (presetn),
        .advance (word_taken),
        .restart (restart_fire),
        .phase   (seq_phase),
        .ramp    (seq_ramp)
    );

    // ------------------------------------------------------------------
    // Word selection
    // ------------------------------------------------------------------
    assign toggle_word = {(DATA_W/2){2'h2}};

    // Each word is built from one value of the select register in one cycle, so a code
    // change lands between words and never splits one.
    assign pattern_word =
        (select_reg == `CODE_ZEROS)  ? '0 :                                     // [R2] [R13]
        (select_reg == `CODE_ONES)   ? '1 :                                     // [R2]
        (select_reg == `CODE_TOGGLE) ? (seq_phase ? ~toggle_word : toggle_word) :  // [R3]
        (select_reg == `CODE_RAMP)   ? seq_ramp :                               // [R4]
        (select_reg == `CODE_SINGLE) ? DATA_W'(user_word_one) :                 // [R5]
        (select_reg == `CODE_DOUBLE) ? (seq_phase ? DATA_W'(user_word_two)      // [R6]
                                                  : DATA_W'(user_word_one)) :
        (select_reg == `CODE_DESKEW) ? DATA_W'(`DESKEW_WORD) :                  // [R7]
                                       sample_data;                             // [R12]

    assign code_is_pattern = (select_reg == `CODE_ZEROS)  || (select_reg == `CODE_ONES)   ||
                             (select_reg == `CODE_TOGGLE) || (select_reg == `CODE_RAMP)   ||
                             (select_reg == `CODE_SINGLE) || (select_reg == `CODE_DOUBLE) ||
                             (select_reg == `CODE_DESKEW);

    assign gen_stream.valid = sample_valid;
    assign gen_stream.data  = code_is_pattern ? pattern_word : sample_data;    // [R1] [R12]

    // ------------------------------------------------------------------
    // Output buffer: a stalled receiver back-pressures the sample source
    // ------------------------------------------------------------------
    pattern_out_buffer #(
        .DATA_W    (DATA_W),
        .DEPTH     (DEPTH)
    ) u_out_buffer (
        .pclk      (pclk),
        .presetn   (presetn),
        .fill      (gen_stream.sink),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );
endmodule

// ---- bench/out_path_model.sv ----
// Downstream output path model that accepts words with random stalls
`timescale 1ns/1ns
module out_path_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Stall rate in percent
    input  wire logic [6:0]  stall_pct,
    // Patterned stream
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire logic [15:0] out_data,
    // Accepted word, one cycle late
    output logic             seen,
    output logic [15:0]      seen_data
);
    // Ready moves even without valid, as a real path may, to shake the buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
            seen      <= 1'b0;
            seen_data <= 16'h0000;
        end else begin
            seen      <= out_valid && out_ready;
            seen_data <= out_data;
            out_ready <= ($urandom % 100) >= stall_pct;
        end
    end
endmodule

// ---- bench/otpg_monitor.sv ----
// Port assertions for the test pattern generator
`timescale 1ns/1ns
module otpg_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pslverr,
    // Streams
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [15:0] out_data
);
    logic [3:0]  mode_reg;
    logic [1:0]  cnt_reg;
    logic        settled_reg;
    logic        prev_ok_reg;
    logic [15:0] prev_reg;
    wire         wr     = psel && penable && pwrite;
    wire         sel_wr = wr && pstrb[0] && paddr[7:2] == 6'h37;
    wire         push   = sample_valid && sample_ready;
    wire         pop    = out_valid && out_ready;
    wire         mapped = (paddr[7:2] >= 6'h33 && paddr[7:2] <= 6'h37) || paddr[7:2] == 6'h3A || paddr[7:2] == 6'h3B;
    // Words queued before a mode change are not judged by the new mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg    <= 4'h0;
            cnt_reg     <= 2'h0;
            settled_reg <= 1'b1;
            prev_ok_reg <= 1'b0;
            prev_reg    <= 16'h0000;
        end else begin
            mode_reg    <= sel_wr ? pwdata[3:0] : mode_reg;
            cnt_reg     <= cnt_reg + 2'(push) - 2'(pop);
            settled_reg <= sel_wr ? 1'b0 : (cnt_reg == 2'h0 || settled_reg);
            prev_ok_reg <= wr ? 1'b0 : ((pop && settled_reg) || prev_ok_reg);
            prev_reg    <= pop ? out_data : prev_reg;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire chk = settled_reg && out_valid;
    sequence s_stall; out_valid && !out_ready; endsequence
    sequence s_hold; out_valid && $stable(out_data); endsequence
    property p_zeros; chk && mode_reg == 4'h1 |-> out_data == 16'h0000; endproperty
    property p_ones; chk && mode_reg == 4'h2 |-> out_data == 16'hFFFF; endproperty
    property p_deskew; chk && mode_reg == 4'h8 |-> out_data == 16'h0FFF; endproperty
    property p_toggle; chk && prev_ok_reg && mode_reg == 4'h3 |-> out_data == ~prev_reg; endproperty
    property p_ramp;
        chk && prev_ok_reg && mode_reg == 4'h4 |-> out_data == (prev_reg == 16'h4000 ? 16'h0 : prev_reg + 16'h1);
    endproperty
    property p_err; psel && penable |-> pslverr == !mapped; endproperty
    property p_full; cnt_reg == 2'h2 |-> !sample_ready; endproperty
    property p_hold; s_stall |=> s_hold; endproperty
    a_zeros: assert property (p_zeros) else $error("zeros word wrong");
    a_ones: assert property (p_ones) else $error("ones word wrong");
    a_deskew: assert property (p_deskew) else $error("deskew word wrong");
    a_toggle: assert property (p_toggle) else $error("toggle word wrong");
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");
    a_err: assert property (p_err) else $error("slave error wrong");
    a_full: assert property (p_full) else $error("full buffer took a sample");
    a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule
bind output_test_pattern_generator otpg_monitor u_mon (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pslverr,
    .sample_valid, .sample_ready, .out_valid, .out_ready, .out_data
);

// ---- bench/testbench.sv ----
// Self-checking bench for the test pattern generator
`timescale 1ns/1ns
`include "otpg_params.svh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        sample_valid, sample_ready, out_valid, out_ready, seen, phase;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] sample_data, out_data, seen_data, w1, w2, ramp;
    logic [6:0]  stall_pct;
    logic [3:0]  mode, pstrb;
    logic [15:0] exp_q[$];
    logic [3:0]  codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
    logic [7:0]  regs[7] = '{8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hE8, 8'hEC};
    int          fail_count;
    int          comparisons;
    output_test_pattern_generator uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .sample_valid, .sample_ready, .sample_data,
        .out_valid, .out_ready, .out_data);
    out_path_model partner (.pclk, .presetn, .stall_pct, .out_valid, .out_ready, .out_data, .seen, .seen_data);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [15:0] pat(input logic [3:0] m, input logic [15:0] d);
        case (m)
            `CODE_ZEROS:  return 16'h0000;
            `CODE_ONES:   return 16'hFFFF;
            `CODE_TOGGLE: return phase ? 16'h5555 : 16'hAAAA;
            `CODE_RAMP:   return ramp;
            `CODE_SINGLE: return w1;
            `CODE_DOUBLE: return phase ? w2 : w1;
            `CODE_DESKEW: return 16'h0FFF;
            default:      return d;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Sequence steps on every taken sample, in every mode
    always @(posedge pclk) begin
        if (presetn && sample_valid && sample_ready) begin
            exp_q.push_back(pat(mode, sample_data));
            phase = ~phase;
            ramp = (ramp == 16'h4000) ? 16'h0000 : ramp + 16'h0001;
        end
        if (seen) begin
            chk({16'h0, seen_data}, {16'h0, exp_q.pop_front()}, "word");
        end
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1, "ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 8'h00);
        chk(rd, e, "read");
    endtask
    task automatic send(input int n);
        for (int k = 0; k < n; k++) begin
            sample_valid <= 1'b1;
            sample_data <= 16'($urandom);
            do @(posedge pclk); while (sample_ready !== 1'b1);
        end
        sample_valid <= 1'b0;
    endtask
    // Modes change only with the buffer empty, so no word mixes two modes
    task automatic setmode(input logic [3:0] m);
        while (exp_q.size() != 0) @(posedge pclk);
        apb(8'hDC, 1'b1, {4'h0, m});
        mode = m;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(40 * 100000);
        fail_count++;
        final_report;
    end
    initial begin
        void'($urandom(32'h40D0));
        {fail_count, comparisons, phase, ramp, mode, w1, w2} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata, sample_valid, sample_data} = '0;
        stall_pct = 7'h1E;
        pstrb = 4'hF;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rdchk(regs[i], 32'h0);
        apb(8'h00, 1'b0, 8'h00);
        chk({31'h0, err}, 32'h1, "unmapped");
        apb(8'hDC, 1'b1, 8'hF5);
        rdchk(8'hDC, 32'h5);
        // Lane 0 strobe low: the write is dropped without an error
        pstrb <= 4'hE;
        apb(8'hDC, 1'b1, 8'h03);
        pstrb <= 4'hF;
        chk({31'h0, err}, 32'h0, "strobe error");
        rdchk(8'hDC, 32'h5);
        $display("test registers done");
        w1 = 16'($urandom);
        w2 = ~w1;
        apb(8'hCC, 1'b1, w1[7:0]);
        apb(8'hD0, 1'b1, w1[15:8]);
        apb(8'hD4, 1'b1, w2[7:0]);
        apb(8'hD8, 1'b1, w2[15:8]);
        rdchk(8'hD0, {24'h0, w1[15:8]});
        rdchk(8'hD4, {24'h0, w2[7:0]});
        foreach (codes[i]) begin
            setmode(codes[i]);
            send(9);
        end
        $display("test codes done");
        setmode(`CODE_RAMP);
        stall_pct <= 7'h64;
        repeat (2) @(posedge pclk);
        send(2);
        #1 chk({31'h0, sample_ready}, 32'h0, "full");
        rdchk(8'hEC, {29'h0, 2'h1, phase});
        stall_pct <= 7'h00;
        if (!phase) send(1);
        apb(8'hE8, 1'b1, 8'h02);
        repeat (2) @(posedge pclk);
        rdchk(8'hEC, {31'h0, phase});
        apb(8'hE8, 1'b1, 8'h00);
        apb(8'hE8, 1'b1, 8'h03);
        phase = 1'b0;
        ramp = 16'h0000;
        repeat (2) @(posedge pclk);
        rdchk(8'hEC, 32'h4);
        rdchk(8'hE8, 32'h3);
        $display("test restart done");
        stall_pct <= 7'h0A;
        send(16390);
        setmode(`CODE_NORMAL);
        $display("test ramp wrap done");
        final_report;
    end
endmodule
